/* rtl/pci_unit.sv */
// Pin change interrupt unit: masks, group enables, sticky flags, vectors
`timescale 1ns/1ps
`default_nettype none
`include "pci_consts.svh"
module pci_unit
  import pci_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [23:0] pins_in,
  input wire pci_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  output logic bus_hit,
  input wire logic global_int_en,
  input wire logic vec_ack,
  input wire pci_vec_t vec_ack_id,
  output logic int_req,
  output pci_vec_t int_vec
);
  // ***********************************************
  // Pin sampling
  // ***********************************************
  logic [23:0] pins_changed;
  pci_pin_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pins_in(pins_in),
    .pins_sync(),
    .pins_changed(pins_changed)
  );

  // ***********************************************
  // Address decode
  // ***********************************************
  logic [7:0] mask_r [`PCI_GROUPS];
  logic [2:0] enable_r;
  logic [2:0] flag_r;
  logic [7:0] data_addr;
  logic sel_flag;
  logic sel_en;
  logic [2:0] sel_mask;
  // The I/O space flag address sits 0x20 below its data space twin; the other registers answer only in data space
  assign data_addr = bus_req.io_space ? bus_req.addr + `PCI_IO_OFS : bus_req.addr;
  assign sel_flag = data_addr == `PCI_FLAG_ADDR;
  assign sel_en = !bus_req.io_space && data_addr == `PCI_ENABLE_ADDR;
  assign sel_mask[0] = !bus_req.io_space && data_addr == `PCI_MASK0_ADDR;
  assign sel_mask[1] = !bus_req.io_space && data_addr == `PCI_MASK1_ADDR;
  assign sel_mask[2] = !bus_req.io_space && data_addr == `PCI_MASK2_ADDR;
  assign bus_hit = sel_flag | sel_en | (|sel_mask);

  // ***********************************************
  // Registers and change detection per group
  // ***********************************************
  logic [2:0] group_change;
  logic [2:0] svc_clr;
  logic [7:0] mask_keep [`PCI_GROUPS];
  assign mask_keep[0] = 8'hFF;
  assign mask_keep[1] = `PCI_MASK1_USED;
  assign mask_keep[2] = 8'hFF;
  genvar g;
  generate
    for (g = 0; g < `PCI_GROUPS; g++) begin : g_grp
      logic [7:0] mask_nxt;
      assign mask_nxt = (bus_req.wr && sel_mask[g]) ? (bus_req.wdata & mask_keep[g]) : mask_r[g];
      // Detection runs regardless of the enable; the enable gates only dispatch
      assign group_change[g] = |(pins_changed[8*g +: 8] & mask_r[g]);
      assign svc_clr[g] = vec_ack && (vec_ack_id == pci_vec_t'(g));
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          mask_r[g] <= `PCI_REG_RESET;
        end else begin
          mask_r[g] <= mask_nxt;
        end
      end
    end
  endgenerate

  logic [2:0] w1c;
  logic [2:0] flag_nxt;
  logic [2:0] enable_nxt;
  assign w1c = (bus_req.wr && sel_flag) ? bus_req.wdata[2:0] : 3'h0;
  // A new change wins over a clear in the same cycle
  assign flag_nxt = group_change | (flag_r & ~w1c & ~svc_clr);
  assign enable_nxt = (bus_req.wr && sel_en) ? bus_req.wdata[2:0] : enable_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_r <= 3'h0;
      enable_r <= 3'h0;
    end else begin
      flag_r <= flag_nxt;
      enable_r <= enable_nxt;
    end
  end

  // ***********************************************
  // Read data
  // ***********************************************
  logic [7:0] rd_mux;
  assign rd_mux = sel_flag ? {5'h00, flag_r} :
                  sel_en ? {5'h00, enable_r} :
                  sel_mask[0] ? mask_r[0] :
                  sel_mask[1] ? mask_r[1] :
                  sel_mask[2] ? mask_r[2] : 8'h00;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_req.rd) begin
      bus_rdata <= rd_mux;
    end
  end

  // ***********************************************
  // Vector dispatch
  // ***********************************************
  logic [2:0] pend;
  assign pend = flag_r & enable_r & {3{global_int_en}};
  assign int_req = |pend;
  // Lowest group has the highest priority, like the vector table order
  assign int_vec = pend[0] ? PCI_VEC_G0 :
                   pend[1] ? PCI_VEC_G1 :
                   pend[2] ? PCI_VEC_G2 : PCI_VEC_NONE;

  // ***********************************************
  // Checks
  // ***********************************************
  AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |(pins_changed[7:0] & mask_r[0]) |=> flag_r[0])
    else $error("group 0 flag not set after masked change");
  AST_G1_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |(pins_changed[15:8] & mask_r[1]) |=> flag_r[1])
    else $error("group 1 flag not set after masked change");
  AST_G2_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    |(pins_changed[23:16] & mask_r[2]) |=> flag_r[2])
    else $error("group 2 flag not set after masked change");
  AST_NO_SPUR_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (group_change == 3'h0) |=> ((flag_r & ~$past(flag_r)) == 3'h0))
    else $error("flag rose without a masked change");
  AST_G2_MASKED: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mask_r[2] == 8'h00 && !flag_r[2] && !(bus_req.wr && sel_mask[2])) |=> !flag_r[2])
    else $error("group 2 flag set with empty mask");
  AST_MASK1_B7: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !mask_r[1][7])
    else $error("group 1 mask bit 7 set");
  AST_MASK0_WR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.wr && sel_mask[0]) |=> (mask_r[0] == $past(bus_req.wdata)))
    else $error("group 0 mask write lost");
  AST_MASK1_WR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.wr && sel_mask[1]) |=> (mask_r[1] == ($past(bus_req.wdata) & `PCI_MASK1_USED)))
    else $error("group 1 mask write lost");
  AST_MASK2_WR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.wr && sel_mask[2]) |=> (mask_r[2] == $past(bus_req.wdata)))
    else $error("group 2 mask write lost");
  // Clear checks leave out the cycle in which a new change wins over the clear
  AST_W1C: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.wr && sel_flag && bus_req.wdata[1] && !group_change[1]) |=> !flag_r[1])
    else $error("write one did not clear group 1 flag");
  AST_W0_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (flag_r[2] && !svc_clr[2] && !(bus_req.wr && sel_flag && bus_req.wdata[2])) |=> flag_r[2])
    else $error("group 2 flag lost without clear");
  AST_SVC_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (svc_clr[0] && !group_change[0]) |=> !flag_r[0])
    else $error("service entry did not clear group 0 flag");
  AST_SVC_G2: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (svc_clr[2] && !group_change[2]) |=> !flag_r[2])
    else $error("service entry did not clear group 2 flag");
  AST_REQ_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    int_req |-> (global_int_en && |(flag_r & enable_r)))
    else $error("request without flag, enable and global bit");
  AST_G1_DISPATCH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (flag_r[1] && enable_r[1] && global_int_en) |-> int_req)
    else $error("group 1 request missing");
  AST_VEC_G0: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (flag_r[0] && enable_r[0] && global_int_en) |-> (int_vec == PCI_VEC_G0))
    else $error("group 0 request on wrong vector");
  AST_VEC_G2: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pend == 3'h4) |-> (int_vec == PCI_VEC_G2))
    else $error("group 2 request on wrong vector");
  AST_VEC_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !int_req |-> (int_vec == PCI_VEC_NONE))
    else $error("vector shown without a request");
  AST_IO_ALIAS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.io_space && bus_req.addr == 8'h1B) |-> sel_flag)
    else $error("flag register not seen at I/O alias");
  AST_IO_ONLY_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.io_space |-> !(sel_en || (|sel_mask)))
    else $error("data space register answered in I/O space");
  AST_EN_WR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (bus_req.wr && sel_en) |=> (enable_r == $past(bus_req.wdata[2:0])))
    else $error("enable register write lost");
  // No disable here, so the reset cycles themselves are watched
  AST_RESET_CLEAR: assert property (@(posedge sys_clk)
    !rst_n |=> (flag_r == 3'h0 && enable_r == 3'h0 && !int_req &&
      mask_r[0] == 8'h00 && mask_r[1] == 8'h00 && mask_r[2] == 8'h00))
    else $error("registers not cleared by reset");
  COV_G0_REQ: cover property (@(posedge sys_clk) disable iff (!rst_n)
    int_req && int_vec == PCI_VEC_G0);
  COV_G1_SVC: cover property (@(posedge sys_clk) disable iff (!rst_n)
    flag_r[1] ##1 svc_clr[1]);
  COV_W1C: cover property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.wr && sel_flag && |(w1c & flag_r));
  COV_SET_CLR: cover property (@(posedge sys_clk) disable iff (!rst_n)
    |(group_change & w1c));
  COV_IO_W1C: cover property (@(posedge sys_clk) disable iff (!rst_n)
    bus_req.io_space && bus_req.wr && sel_flag);
endmodule
`default_nettype wire

/* rtl/pci_consts.svh */
// Offsets, field positions and reset values of the pin change interrupt unit
`ifndef PCI_CONSTS_SVH
`define PCI_CONSTS_SVH
`define PCI_IO_OFS 8'h20
`define PCI_FLAG_ADDR 8'h3B
`define PCI_ENABLE_ADDR 8'h68
`define PCI_MASK0_ADDR 8'h6B
`define PCI_MASK1_ADDR 8'h6C
`define PCI_MASK2_ADDR 8'h6D
`define PCI_GROUPS 3
`define PCI_PINS 24
`define PCI_MASK1_USED 8'h7F
`define PCI_REG_RESET 8'h00
`define PCI_SYNC_RESET 24'h000000
`define PCI_ARM_RESET 3'h0
`endif

/* rtl/pci_pkg.sv */
// Types shared by the pin change interrupt unit
package pci_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic io_space;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pci_bus_req_t;
  typedef enum logic [1:0] {
    PCI_VEC_G0,
    PCI_VEC_G1,
    PCI_VEC_G2,
    PCI_VEC_NONE
  } pci_vec_t;
endpackage

/* rtl/pci_pin_sync.sv */
// Two-stage synchroniser and change detector for the monitored pins
`timescale 1ns/1ps
`default_nettype none
`include "pci_consts.svh"
module pci_pin_sync (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [23:0] pins_in,
  output logic [23:0] pins_sync,
  output logic [23:0] pins_changed
);
  logic [23:0] meta_r;
  logic [23:0] sync_r;
  logic [23:0] prev_r;
  logic [2:0] arm_r;
  logic armed;
  // First stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_r <= `PCI_SYNC_RESET;
      sync_r <= `PCI_SYNC_RESET;
      prev_r <= `PCI_SYNC_RESET;
      arm_r <= `PCI_ARM_RESET;
    end else begin
      meta_r <= pins_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      arm_r <= {arm_r[1:0], 1'b1};
    end
  end
  // Reset clears the stages, so a pin held high would look like a change;
  // detection waits until prev holds a real sample, a change in that gap is lost
  assign armed = arm_r[2];
  assign pins_sync = sync_r;
  assign pins_changed = armed ? (sync_r ^ prev_r) : `PCI_SYNC_RESET;
endmodule
`default_nettype wire

/* tb/pci_pin_drv.sv */
// Model of the external lines that toggle the monitored pins
`timescale 1ns/1ps
`default_nettype none
module pci_pin_drv (
  input wire logic sys_clk,
  input wire logic [23:0] tog,
  output logic [23:0] pins
);
  // Lines move on the falling edge so they never race the sampling edge
  initial pins = 24'h000000;
  always @(negedge sys_clk) begin
    pins <= pins ^ tog;
  end
endmodule
`default_nettype wire

/* tb/pci_unit_tb_top.sv */
// Self-checking bench for the pin change interrupt unit
`timescale 1ns/1ps
`default_nettype none
module pci_unit_tb_top;
  import pci_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [23:0] tog = 24'h000000;
  logic [23:0] pins;
  pci_bus_req_t bus_req = '0;
  logic [7:0] bus_rdata;
  logic bus_hit, int_req, global_int_en = 1'b1, vec_ack = 1'b0, rd_seen = 1'b0;
  logic hit_seen = 1'b0;
  pci_vec_t vec_ack_id = PCI_VEC_NONE;
  pci_vec_t int_vec;
  logic [11:0] exp_q[$];
  logic [11:0] e;
  logic [11:0] got;
  logic [7:0] ra[6] = '{8'h3B, 8'h68, 8'h6B, 8'h6C, 8'h6D, 8'h50};
  logic [7:0] m;
  int mismatches = 0, n_checks = 0, cyc = 0, p;
  always #25 sys_clk = ~sys_clk;
  pci_pin_drv pci_pin_drv_i (.sys_clk(sys_clk), .tog(tog), .pins(pins));
  pci_unit pci_unit_i (.sys_clk(sys_clk), .rst_n(rst_n), .pins_in(pins), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_hit(bus_hit), .global_int_en(global_int_en),
    .vec_ack(vec_ack), .vec_ack_id(vec_ack_id), .int_req(int_req), .int_vec(int_vec));
  // ****************
  // Bus and pin tasks
  // ****************
  task automatic print_verdict();
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
    @(negedge sys_clk);
    bus_req <= '{a, io, 1'b1, 1'b0, d};
    @(negedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask
  // Each read also notes the request state expected when its data lands
  task automatic rd(input logic [7:0] a, input logic io, input logic [7:0] d, input logic r,
    input pci_vec_t v);
    logic h;
    h = io ? (a == 8'h1B) : (a == 8'h3B || a == 8'h68 || (a >= 8'h6B && a <= 8'h6D));
    exp_q.push_back({d, h, r, v});
    @(negedge sys_clk);
    bus_req <= '{a, io, 1'b0, 1'b1, 8'h00};
    @(negedge sys_clk);
    bus_req.rd <= 1'b0;
  endtask
  // Waits out the synchroniser before anything is read back
  task automatic tg(input logic [23:0] t);
    @(negedge sys_clk);
    tog <= t;
    @(negedge sys_clk);
    tog <= 24'h000000;
    repeat (5) @(negedge sys_clk);
  endtask
  task automatic ack(input pci_vec_t v);
    @(negedge sys_clk);
    vec_ack <= 1'b1;
    vec_ack_id <= v;
    @(negedge sys_clk);
    vec_ack <= 1'b0;
  endtask
  // ****************
  // Result watcher
  // ****************
  always @(posedge sys_clk) begin
    rd_seen <= bus_req.rd;
    hit_seen <= bus_hit;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      print_verdict();
    end
  end
  always @(negedge sys_clk) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      got = {bus_rdata, hit_seen, int_req, int_vec};
      n_checks++;
      if (got !== e) begin
        mismatches++;
        $display("wrong value at %0t: got %h want %h", $time, got, e);
      end
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(13));
    repeat (6) @(negedge sys_clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], 1'b0, 8'h00, 1'b0, PCI_VEC_NONE);
    rd(8'h1B, 1'b1, 8'h00, 1'b0, PCI_VEC_NONE);
    for (int g = 0; g < 3; g++) begin
      m = 8'($urandom());
      wr(8'(8'h6B + g), 1'b0, m);
      rd(8'(8'h6B + g), 1'b0, (g == 1) ? (m & 8'h7F) : m, 1'b0, PCI_VEC_NONE);
    end
    for (int g = 0; g < 3; g++) begin
      wr(8'(8'h6B + g), 1'b0, 8'hFF);
      p = 8 * g + int'($urandom_range(g == 1 ? 6 : 7));
      tg(24'h000001 << p);
      rd(8'h3B, 1'b0, 8'(8'h01 << g), 1'b0, PCI_VEC_NONE);
      wr(8'h68, 1'b0, 8'(8'h01 << g));
      rd(8'h68, 1'b0, 8'(8'h01 << g), 1'b1, pci_vec_t'(g));
      ack(pci_vec_t'(g));
      rd(8'h3B, 1'b0, 8'h00, 1'b0, PCI_VEC_NONE);
    end
    // Masked-off pin 0 and the unused pin 15 must stay silent
    wr(8'h6B, 1'b0, 8'hFE);
    tg(24'h008001);
    rd(8'h3B, 1'b0, 8'h00, 1'b0, PCI_VEC_NONE);
    global_int_en <= 1'b0;
    tg(24'h010102);
    rd(8'h3B, 1'b0, 8'h07, 1'b0, PCI_VEC_NONE);
    wr(8'h3B, 1'b0, 8'h00);
    rd(8'h3B, 1'b0, 8'h07, 1'b0, PCI_VEC_NONE);
    wr(8'h1B, 1'b1, 8'h02);
    rd(8'h1B, 1'b1, 8'h05, 1'b0, PCI_VEC_NONE);
    wr(8'h68, 1'b0, 8'h07);
    global_int_en <= 1'b1;
    rd(8'h68, 1'b0, 8'h07, 1'b1, PCI_VEC_G0);
    wr(8'h3B, 1'b0, 8'h05);
    rd(8'h3B, 1'b0, 8'h00, 1'b0, PCI_VEC_NONE);
    rd(8'h48, 1'b1, 8'h00, 1'b0, PCI_VEC_NONE);
    // A pin left high across reset must not count as a change
    rst_n <= 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n <= 1'b1;
    wr(8'h6B, 1'b0, 8'hFF);
    repeat (4) @(negedge sys_clk);
    rd(8'h3B, 1'b0, 8'h00, 1'b0, PCI_VEC_NONE);
    rd(8'h6D, 1'b0, 8'h00, 1'b0, PCI_VEC_NONE);
    tg(24'h000004);
    rd(8'h3B, 1'b0, 8'h01, 1'b0, PCI_VEC_NONE);
    repeat (3) @(negedge sys_clk);
    print_verdict();
  end
endmodule
`default_nettype wire
